/* logic/hef_map.vh */
`ifndef HEF_MAP_VH
`define HEF_MAP_VH

// register addresses
`define HEF_ADDR_THRESH   5'h06
`define HEF_ADDR_POLES    5'h07
`define HEF_ADDR_STATUS   5'h1B

// frame opcodes
`define HEF_OP_READ       3'h2
`define HEF_OP_WRITE      3'h4

// frame layout, 16 bits msb first
`define HEF_FRAME_BITS    5'h10
`define HEF_OP_HI         15
`define HEF_OP_LO         13
`define HEF_AD_HI         12
`define HEF_AD_LO         8
`define HEF_DAT_HI        7
`define HEF_DAT_LO        0

// threshold register fields
`define HEF_LOW_THR_HI    5
`define HEF_LOW_THR_LO    3
`define HEF_HIGH_THR_HI   2
`define HEF_HIGH_THR_LO   0
`define HEF_THRESH_RST    8'h00
`define HEF_POLES_RST     8'h00

// status register bit positions
`define HEF_ST_HIGH       7
`define HEF_ST_LOW        6
`define HEF_ST_COPY_A     3
`define HEF_ST_COPY_B     2

// rising field thresholds in mT per 3-bit code
`define HEF_THR_0         8'h1A
`define HEF_THR_1         8'h29
`define HEF_THR_2         8'h38
`define HEF_THR_3         8'h46
`define HEF_THR_4         8'h54
`define HEF_THR_5         8'h62
`define HEF_THR_6         8'h70
`define HEF_THR_7         8'h7E
`define HEF_FIELD_HYS     8'h06

// commutation states per electrical cycle
`define HEF_STATES        6'h06
`define HEF_POLE_ONE      6'h01

// spurious low-flag pulse, angles in degrees, span in tenths
`define HEF_GL_DEG_0      44
`define HEF_GL_DEG_1      138
`define HEF_GL_DEG_2      224
`define HEF_GL_DEG_3      318
`define HEF_GL_SPAN_TENTH 15
`define HEF_DEG_FULL      360
`define HEF_TENTH_FULL    3600
`define HEF_CLK_NS        100
`define HEF_GL_PULSE_NS   1400
`define HEF_GL_GAP_NS     100000
`define HEF_LFSR_SEED     16'hACE1
`define HEF_LFSR_TAPS     16'hB400

`endif

/* logic/hef_top.v */
// Summary of operation
// - status bits 7 and 6 hold field flags
// - field flags also driven on two pins
// - read data returned in next frame
// - low flag shows short spurious high pulses
// - pulses only near 44,138,224,318 degrees
// - spurious pulses at least 100 us apart
// - three 50 percent outputs, 120 electrical degrees apart
// - angle divided into steps per pole pairs
// - pole field plus one gives pole pairs
// - hysteresis on single-step commutation transitions
// - low threshold may exceed high threshold
// - flags show field outside threshold range
// - register 6 holds both 3-bit thresholds
`timescale 1ns/100ps
`include "hef_map.vh"

module hef_top #(
  parameter ANG_W   = 12,
  parameter UVW_HYS = 16
) (
  // clock and reset
  input  wire             i_mclk,
  input  wire             i_nrst,
  // sensor inputs, same clock domain
  input  wire [ANG_W-1:0] i_angle,
  input  wire [7:0]       i_field,
  // serial port pins
  input  wire             i_sck,
  input  wire             i_cs_n,
  input  wire             i_mosi,
  output wire             o_miso,
  output reg              o_miso_oe,
  // flag pins
  output reg              o_field_high_flag,
  output reg              o_field_low_flag,
  // commutation outputs
  output wire [2:0]       o_commutation_triplet
);
  localparam integer FULL     = 1 << ANG_W;
  // half window shrunk by half a count so centre rounding stays inside
  localparam integer GL_HALF  = (2 * `HEF_GL_SPAN_TENTH * FULL -
                                 `HEF_TENTH_FULL) /
                                (2 * `HEF_TENTH_FULL);
  localparam integer PULSE_CY = `HEF_GL_PULSE_NS / `HEF_CLK_NS;
  localparam integer GAP_CY   = (`HEF_GL_GAP_NS + `HEF_CLK_NS - 1) /
                                `HEF_CLK_NS;

  // synchronisers for the serial pins
  reg  [2:0]  sck_sync_reg;
  reg  [2:0]  cs_sync_reg;
  reg  [1:0]  mosi_sync_reg;
  // serial engine
  reg  [15:0] rx_reg;
  reg  [15:0] tx_reg;
  reg  [4:0]  cnt_reg;
  reg  [7:0]  resp_reg;
  reg  [7:0]  thresh_reg;
  reg  [7:0]  poles_reg;
  // field flag state
  reg         high_true_reg;
  reg         low_true_reg;
  reg  [15:0] lfsr_reg;
  reg  [3:0]  pulse_reg;
  reg  [9:0]  gap_reg;
  reg  [7:0]  status_reg;
  reg  [7:0]  rd_data;
  reg  [7:0]  thr_low_rise;
  reg  [7:0]  thr_high_rise;
  wire        sck_rise;
  wire        sck_fall;
  wire        cs_fall;
  wire        cs_active;
  wire [15:0] frame;
  wire [3:0]  near_win;
  wire        glitch;
  wire        low_pin;

  // rising thresholds from a 3-bit code
  function [7:0] thr_of;
    input [2:0] code;
    begin
      case (code)
        3'h0:    thr_of = `HEF_THR_0;
        3'h1:    thr_of = `HEF_THR_1;
        3'h2:    thr_of = `HEF_THR_2;
        3'h3:    thr_of = `HEF_THR_3;
        3'h4:    thr_of = `HEF_THR_4;
        3'h5:    thr_of = `HEF_THR_5;
        3'h6:    thr_of = `HEF_THR_6;
        default: thr_of = `HEF_THR_7;
      endcase
    end
  endfunction

  // pin synchronisers, first stage feeds only the second
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      sck_sync_reg  <= 3'h0;
      cs_sync_reg   <= 3'h7;
      mosi_sync_reg <= 2'h0;
    end else begin
      sck_sync_reg  <= {sck_sync_reg[1:0], i_sck};
      cs_sync_reg   <= {cs_sync_reg[1:0], i_cs_n};
      mosi_sync_reg <= {mosi_sync_reg[0], i_mosi};
    end
  end

  assign sck_rise  = sck_sync_reg[1] & ~sck_sync_reg[2];
  assign sck_fall  = ~sck_sync_reg[1] & sck_sync_reg[2];
  assign cs_fall   = ~cs_sync_reg[1] & cs_sync_reg[2];
  assign cs_active = ~cs_sync_reg[1];
  assign frame     = {rx_reg[14:0], mosi_sync_reg[1]};
  assign o_miso    = tx_reg[15];

  // readable value for an address
  always @* begin
    case (frame[`HEF_AD_HI:`HEF_AD_LO])
      `HEF_ADDR_THRESH: rd_data = thresh_reg;
      `HEF_ADDR_POLES:  rd_data = poles_reg;
      `HEF_ADDR_STATUS: rd_data = status_reg;
      default:          rd_data = 8'h00;
    endcase
  end

  // serial slave: sample on rising sck, shift out on falling
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      rx_reg     <= 16'h0000;
      tx_reg     <= 16'h0000;
      cnt_reg    <= 5'h00;
      resp_reg   <= 8'h00;
      thresh_reg <= `HEF_THRESH_RST;
      poles_reg  <= `HEF_POLES_RST;
      o_miso_oe  <= 1'b0;
    end else begin
      o_miso_oe <= cs_active;
      if (cs_fall) begin
        tx_reg  <= {resp_reg, 8'h00};
        cnt_reg <= 5'h00;
      end else if (cs_active) begin
        if (sck_rise && cnt_reg != `HEF_FRAME_BITS) begin
          rx_reg  <= frame;
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == `HEF_FRAME_BITS - 5'h01) begin
            if (frame[`HEF_OP_HI:`HEF_OP_LO] == `HEF_OP_READ)
              resp_reg <= rd_data;
            else if (frame[`HEF_OP_HI:`HEF_OP_LO] == `HEF_OP_WRITE) begin
              // thresholds stored as given, in any order
              if (frame[`HEF_AD_HI:`HEF_AD_LO] == `HEF_ADDR_THRESH)
                thresh_reg <= frame[`HEF_DAT_HI:`HEF_DAT_LO];
              if (frame[`HEF_AD_HI:`HEF_AD_LO] == `HEF_ADDR_POLES)
                poles_reg <= frame[`HEF_DAT_HI:`HEF_DAT_LO];
            end
          end
        end
        if (sck_fall)
          tx_reg <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  // thresholds taken from register 6 fields
  always @* begin
    thr_low_rise  = thr_of(thresh_reg[`HEF_LOW_THR_HI:`HEF_LOW_THR_LO]);
    thr_high_rise = thr_of(thresh_reg[`HEF_HIGH_THR_HI:`HEF_HIGH_THR_LO]);
  end

  // out-of-range detection with field hysteresis
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      high_true_reg <= 1'b0;
      low_true_reg  <= 1'b1;
    end else begin
      if (i_field >= thr_high_rise)
        high_true_reg <= 1'b1;
      else if (i_field < thr_high_rise - `HEF_FIELD_HYS)
        high_true_reg <= 1'b0;
      if (i_field < thr_low_rise - `HEF_FIELD_HYS)
        low_true_reg <= 1'b1;
      else if (i_field >= thr_low_rise)
        low_true_reg <= 1'b0;
    end
  end

  // angle windows around the four trouble spots
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_win
      localparam integer DEG = (gi == 0) ? `HEF_GL_DEG_0 :
                               (gi == 1) ? `HEF_GL_DEG_1 :
                               (gi == 2) ? `HEF_GL_DEG_2 : `HEF_GL_DEG_3;
      localparam integer     CTR_I = (DEG * FULL + `HEF_DEG_FULL / 2) /
                                     `HEF_DEG_FULL;
      localparam [ANG_W-1:0] CTR   = CTR_I[ANG_W-1:0];
      localparam [ANG_W-1:0] HLF   = GL_HALF[ANG_W-1:0];
      wire [ANG_W-1:0] diff = i_angle - CTR;
      assign near_win[gi] = (diff <= HLF) || (diff >= ~HLF + 1'b1);
    end
  endgenerate

  assign glitch  = (pulse_reg != 4'h0);
  assign low_pin = low_true_reg | glitch;

  // pseudo-random spurious pulse generator with spacing
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      lfsr_reg  <= `HEF_LFSR_SEED;
      pulse_reg <= 4'h0;
      gap_reg   <= 10'h000;
    end else begin
      lfsr_reg <= lfsr_reg[0] ? (lfsr_reg >> 1) ^ `HEF_LFSR_TAPS
                              : (lfsr_reg >> 1);
      if (gap_reg != 10'h000)
        gap_reg <= gap_reg - 10'h001;
      if (pulse_reg != 4'h0)
        pulse_reg <= pulse_reg - 4'h1;
      if (gap_reg == 10'h000 && (|near_win) && lfsr_reg[3:0] == 4'h0) begin
        pulse_reg <= PULSE_CY[3:0];
        gap_reg   <= GAP_CY[9:0] - 10'h001;
      end
    end
  end

  // flag pins and status byte
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_field_high_flag <= 1'b0;
      o_field_low_flag  <= 1'b1;
      status_reg        <= 8'h40;
    end else begin
      o_field_high_flag <= high_true_reg;
      o_field_low_flag  <= low_pin;
      status_reg                 <= 8'h00;
      status_reg[`HEF_ST_HIGH]   <= high_true_reg;
      status_reg[`HEF_ST_LOW]    <= low_pin;
      status_reg[`HEF_ST_COPY_A] <= ~low_true_reg;
      status_reg[`HEF_ST_COPY_B] <= ~low_true_reg;
    end
  end

  // commutation triplet generator
  hef_uvw #(
    .ANG_W (ANG_W),
    .HYS   (UVW_HYS)
  ) u_uvw (
    .i_mclk                (i_mclk),
    .i_nrst                (i_nrst),
    .i_angle               (i_angle),
    .i_pole_pair_count     (poles_reg[2:0]),
    .o_commutation_triplet (o_commutation_triplet)
  );
endmodule

/* logic/hef_uvw.v */
`timescale 1ns/100ps
`include "hef_map.vh"

module hef_uvw #(
  parameter ANG_W = 12,
  parameter HYS   = 16
) (
  // clock and reset
  input  wire             i_mclk,
  input  wire             i_nrst,
  // angle and configuration
  input  wire [ANG_W-1:0] i_angle,
  input  wire [2:0]       i_pole_pair_count,
  // commutation triplet u, v, w
  output reg  [2:0]       o_commutation_triplet
);
  localparam PW = ANG_W + 6;

  reg  [5:0]    sect_reg;
  reg  [5:0]    sect_next;
  reg  [2:0]    pat;
  wire [5:0]    n_states;
  wire [PW-1:0] pos;
  wire [5:0]    cand;
  wire [ANG_W-1:0] frac;
  wire [5:0]    up;
  wire [5:0]    dn;
  wire [5:0]    phase;

  // states per revolution: six per pole pair
  assign n_states = ({3'h0, i_pole_pair_count} + `HEF_POLE_ONE) *
                    `HEF_STATES;
  // scale angle into step units
  assign pos  = {6'h00, i_angle} * {{ANG_W{1'b0}}, n_states};
  assign cand = pos[PW-1:ANG_W];
  assign frac = pos[ANG_W-1:0];
  assign up   = (sect_reg == n_states - 6'h01) ? 6'h00 : sect_reg + 6'h01;
  assign dn   = (sect_reg == 6'h00) ? n_states - 6'h01 : sect_reg - 6'h01;

  // single steps only once past the boundary by the hysteresis margin, larger jumps at once
  always @* begin
    sect_next = sect_reg;
    if (cand != sect_reg) begin
      if (cand == up) begin
        if (frac >= HYS[ANG_W-1:0])
          sect_next = cand;
      end else if (cand == dn) begin
        if (frac <= ~HYS[ANG_W-1:0])
          sect_next = cand;
      end else begin
        sect_next = cand; // large jump or pole change
      end
    end
  end

  assign phase = sect_reg % `HEF_STATES;

  // one output changes per step, order follows direction
  always @* begin
    case (phase)
      6'h00:   pat = 3'h4;
      6'h01:   pat = 3'h6;
      6'h02:   pat = 3'h2;
      6'h03:   pat = 3'h3;
      6'h04:   pat = 3'h1;
      6'h05:   pat = 3'h5;
      default: pat = 3'h4;
    endcase
  end

  // sector and triplet registers
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      sect_reg              <= 6'h00;
      o_commutation_triplet <= 3'h4;
    end else begin
      sect_reg              <= sect_next;
      o_commutation_triplet <= pat;
    end
  end
endmodule

/* tb/hef_host.sv */
`timescale 1ns/100ps
// serial host, mode 0, msb first
module hef_host (
  input  wire i_mclk,
  input  wire i_miso,
  input  wire i_miso_oe,
  output reg  o_sck,
  output reg  o_cs_n,
  output reg  o_mosi
);
  reg  last;
  wire line = i_miso_oe ? i_miso : ~last;
  // released line toggles every cycle
  always @(posedge i_mclk) last <= line;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    last = 1'b0;
  end
  // one frame, four clocks per half bit
  task frame(input [15:0] tx, output [15:0] rx);
    integer i;
    begin
      @(negedge i_mclk) o_cs_n = 1'b0;
      repeat (2) @(negedge i_mclk);
      for (i = 15; i >= 0; i = i - 1) begin
        o_mosi = tx[i];
        repeat (4) @(negedge i_mclk);
        o_sck = 1'b1;
        rx[i] = line;
        repeat (4) @(negedge i_mclk);
        o_sck = 1'b0;
      end
      repeat (4) @(negedge i_mclk);
      o_cs_n = 1'b1;
      repeat (6) @(negedge i_mclk);
    end
  endtask
  // command frame, byte comes in the filler
  task rd(input [4:0] a, output [7:0] d);
    reg [15:0] r;
    begin
      frame({3'h2, a, 8'h00}, r);
      frame(16'h0000, r);
      d = r[15:8];
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    reg [15:0] r;
    frame({3'h4, a, d}, r);
  endtask
  // low flag rebuilt from the two copies
  function lo_fix(input [7:0] s);
    lo_fix = !(s[3] | s[2]);
  endfunction
endmodule

/* tb/hef_top_properties.sv */
`timescale 1ns/100ps
// port checks for hef_top
module hef_top_properties #(
  parameter ANG_W   = 12,
  parameter UVW_HYS = 16
) (
  input wire             i_mclk,
  input wire             i_nrst,
  input wire [ANG_W-1:0] i_angle,
  input wire [7:0]       i_field,
  input wire             i_sck,
  input wire             i_cs_n,
  input wire             i_mosi,
  input wire             o_miso,
  input wire             o_miso_oe,
  input wire             o_field_high_flag,
  input wire             o_field_low_flag,
  input wire [2:0]       o_commutation_triplet
);
  reg  [3:0]  calm;
  reg  [10:0] gap;
  reg         lo_d;
  wire        glit = calm[3] & o_field_low_flag & ~lo_d;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // angle within 1.6 deg of a pulse angle
  function near(input [ANG_W-1:0] a);
    integer t;
    begin
      t = a * 3600 / (1 << ANG_W);
      near = (t > 424 && t < 456) || (t > 1364 && t < 1396) ||
             (t > 2224 && t < 2256) || (t > 3164 && t < 3196);
    end
  endfunction
  // quiet time, pulse gap, last low level
  always @(posedge i_mclk) begin
    lo_d <= o_field_low_flag;
    if (!i_nrst) begin
      calm <= 4'h0;
      gap  <= 11'h7FF;
    end else begin
      if (!$stable(i_angle) || !$stable(i_field) || !$stable(i_cs_n))
        calm <= 4'h0;
      else if (calm != 4'hF)
        calm <= calm + 4'h1;
      if (glit)
        gap <= 11'h001;
      else if (gap != 11'h7FF)
        gap <= gap + 11'h001;
    end
  end
  a_glitch_place: assert property (glit |-> near(i_angle))
    else $error("low pulse away from pulse angles");
  a_glitch_width: assert property (
    glit |-> o_field_low_flag [*8] ##1 o_field_low_flag [*5]
    ##[1:3] !o_field_low_flag) else $error("low pulse width wrong");
  a_glitch_gap: assert property (glit |-> gap >= 11'h3E8)
    else $error("low pulses too close");
  a_uvw_legal: assert property (
    !(&o_commutation_triplet) && |o_commutation_triplet)
    else $error("triplet all equal");
  a_uvw_one_bit: assert property (
    $countones(o_commutation_triplet ^ $past(o_commutation_triplet)) < 2)
    else $error("triplet moved two bits");
  a_uvw_steady: assert property (
    calm > 4'h3 && $stable(i_angle) |-> $stable(o_commutation_triplet))
    else $error("triplet moved at still angle");
  a_oe_on: assert property ($fell(i_cs_n) |-> ##[2:5] o_miso_oe)
    else $error("miso not driven in frame");
  a_oe_off: assert property ($rose(i_cs_n) |-> ##[2:5] !o_miso_oe)
    else $error("miso driven after frame");
  c_pulse: cover property (glit);
  c_step: cover property ($changed(o_commutation_triplet));
  c_frame: cover property ($fell(i_cs_n));
endmodule
bind hef_top hef_top_properties #(.ANG_W(ANG_W), .UVW_HYS(UVW_HYS)) u_prop (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_angle(i_angle), .i_field(i_field),
  .i_sck(i_sck), .i_cs_n(i_cs_n), .i_mosi(i_mosi), .o_miso(o_miso),
  .o_miso_oe(o_miso_oe), .o_field_high_flag(o_field_high_flag),
  .o_field_low_flag(o_field_low_flag),
  .o_commutation_triplet(o_commutation_triplet));

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  reg         mclk, nrst, t;
  reg  [11:0] angle;
  reg  [7:0]  field, d;
  wire        sck, cs_n, mosi, miso, oe, hi, lo;
  wire [2:0]  uvw;
  integer     errors, cmp_count, n, s, k;
  // pattern by sector and {field, status} table
  wire [17:0] pat = 18'h296B4;
  wire [95:0] ft = {8'h24, 8'hC0, 8'h29, 8'hC0, 8'h26, 8'h40,
                    8'h1E, 8'h40, 8'h32, 8'hC0, 8'h82, 8'h8C};
  hef_top dut (.i_mclk(mclk), .i_nrst(nrst), .i_angle(angle),
    .i_field(field), .i_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi),
    .o_miso(miso), .o_miso_oe(oe), .o_field_high_flag(hi),
    .o_field_low_flag(lo), .o_commutation_triplet(uvw));
  hef_host host (.i_mclk(mclk), .i_miso(miso), .i_miso_oe(oe),
    .o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // low pin read again 20 us later when high
  task dbl(output v);
    begin
      v = lo;
      if (v === 1'b1) begin
        repeat (200) @(negedge mclk);
        v = lo;
      end
    end
  endtask
  initial begin
    errors = 0;
    cmp_count = 0;
    nrst = 1'b0;
    angle = 12'h014;
    field = 8'h82;
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    host.rd(5'h1B, d); chk("status", 8'h8C, d);
    chk("pins", 8'h02, {6'h0, hi, lo});
    host.rd(5'h06, d); chk("thresh", 8'h00, d);
    host.rd(5'h07, d); chk("poles", 8'h00, d);
    host.rd(5'h10, d); chk("unmapped", 8'h00, d);
    $display("test reset done");
    host.wr(5'h06, 8'h39);
    host.rd(5'h06, d); chk("thresh", 8'h39, d);
    for (k = 0; k < 6; k++) begin
      field = ft[16*k+8 +: 8];
      repeat (6) @(negedge mclk);
      host.rd(5'h1B, d); chk("status", ft[16*k +: 8], d);
      chk("pins", {6'h0, ft[16*k+6 +: 2]}, {6'h0, hi, lo});
      chk("fix", {7'h0, ft[16*k+6]}, {7'h0, host.lo_fix(d)});
    end
    host.wr(5'h06, 8'h00);
    $display("test thresholds done");
    for (n = 0; n < 8; n++) begin
      host.wr(5'h07, n[7:0]);
      host.rd(5'h07, d); chk("poles", n[7:0], d);
      for (s = 0; s < 12 * (n + 1); s++) begin
        k = (s < 6 * (n + 1)) ? s : 12 * (n + 1) - 1 - s;
        angle = 12'((2 * k + 1) * 4096 / (12 * (n + 1)));
        repeat (4) @(negedge mclk);
        chk("uvw", {5'h0, pat[3*(k%6) +: 3]}, {5'h0, uvw});
      end
    end
    $display("test commutation done");
    host.wr(5'h07, 8'h00);
    // just past a boundary the triplet must hold, further on it steps
    angle = 12'h2AB;
    repeat (4) @(negedge mclk);
    chk("hys_hold", 8'h04, {5'h0, uvw});
    angle = 12'h2B2;
    repeat (4) @(negedge mclk);
    chk("hys_step", 8'h06, {5'h0, uvw});
    angle = 12'h2A9;
    repeat (4) @(negedge mclk);
    chk("hys_back", 8'h06, {5'h0, uvw});
    angle = 12'h2A6;
    repeat (4) @(negedge mclk);
    chk("hys_down", 8'h04, {5'h0, uvw});
    angle = 12'h1F4;
    k = 0;
    for (s = 0; s < 5000; s++) begin
      @(negedge mclk);
      if (lo === 1'b1) begin
        k++;
        dbl(t); chk("dbl", 8'h00, {7'h0, t});
        chk("inv_high", 8'h00, {7'h0, ~hi});
      end
    end
    chk("pulses", 8'h01, {7'h0, k > 0});
    angle = 12'h400;
    // a pulse launched just before the move may still be running
    repeat (20) @(negedge mclk);
    k = 0;
    repeat (3000) @(negedge mclk) if (lo !== 1'b0) k++;
    chk("quiet", 8'h00, {7'h0, k != 0});
    field = 8'h0A;
    repeat (6) @(negedge mclk);
    dbl(t); chk("dbl", 8'h01, {7'h0, t});
    $display("test field pulses done");
    wrap_up;
  end
  // watchdog over the expected run time
  initial begin
    #4000000;
    errors = errors + 1;
    wrap_up;
  end
endmodule
